// ---- shared/rsrb_pkg.sv ----
// Constants for the reset state and RAM back-up sequencer.
// Assumes a 4-bit core whose registers are held outside and loaded from these values.
package rsrb_pkg;
   // Widths
   localparam int NIB_W = 4;
   localparam int PC_W  = 13;
   // Reset values of control registers
   localparam logic [3:0]  CLK_CTRL_RST   = 4'h8;
   localparam logic [3:0]  NIB_ZERO_RST   = 4'h0;
   localparam logic [3:0]  LATCH_ONE_RST  = 4'hF;
   localparam logic [12:0] PC_RST         = 13'h0000;
   // Supply drop filter length in cycles
   localparam int DROP_SYNC_STAGES = 2;
   // Sequencer states
   typedef enum logic [1:0] {
      RSRB_RUN,
      RSRB_ARMED,
      RSRB_BACKUP
   } rsrb_state_e;
endpackage

// ---- src/rsrb_seq.sv ----
// Reset state and RAM back-up sequencer for a 4-bit microcontroller core.
// Assumes clk_sys_i is the machine cycle; pins sampled through rsrb_sync.
//
// Notes on behaviour
// - During reset all general port pins are released to high impedance.
// - Reset sets output latches of marked port bits to one.
// - Reset turns key-wakeup port pull-ups off and clears pull-up control.
// - After reset port 5 is input; its direction register is zero.
// - Reset loads program counter with address 0 of page 0.
// - Reset clears interrupt enable, request flags and interrupt control registers.
// - Reset clears timer control registers and all watchdog flags.
// - Reset loads clock control with top bit set, others clear.
// - Reset clears serial mode register and serial done flag.
// - Reset clears key-wakeup, converter control registers and conversion done flag.
// - Reset clears comparator control register, disabling both comparators.
// - A supply-drop detection forces a system reset.
// - Back-up entered only when arm op directly precedes power-off op.
// - Power-off op without preceding arm op acts as no-operation.
// - In back-up the oscillator stops; RAM and reset function remain.
// - Waking from back-up by external signal sets standby flag.
// - Cold start clears standby flag and starts at address 0.
// - Back-up is left on an external wakeup signal or on a cold reset.
`timescale 1ns/1ps
`default_nettype none
module rsrb_seq (
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        nrst_i,
   // Asynchronous reset sources and wakeup
   input  wire logic        reset_pin_n_i,
   input  wire logic        supply_drop_i,
   input  wire logic        wakeup_i,
   // Reset from watchdog logic, same clock
   input  wire logic        watchdog_rst_i,
   // Decoded instruction strobes, one per executed instruction
   input  wire logic        instr_valid_i,
   input  wire logic        power_off_arm_op_i,
   input  wire logic        power_off_op_i,
   // Combined system reset, active high
   output logic             sys_rst_o,
   // Oscillator control and back-up status
   output logic             osc_run_o,
   output logic             backup_o,
   output logic             standby_flag_o,
   // Port controls
   output logic             port_oe_o,
   output logic [3:0]       port_latch_o,
   output logic [3:0]       pullup_ctrl_reg_o,
   output logic             pullup_en_o,
   output logic [3:0]       port5_direction_reg_o,
   // Program counter load
   output logic [12:0]      pc_load_o,
   // Interrupt state
   output logic             global_irq_allow_o,
   output logic [5:0]       irq_req_flags_o,
   output logic [3:0]       irq_ctrl1_reg_o,
   output logic [3:0]       irq_ctrl2_reg_o,
   // Timers and watchdog
   output logic [3:0]       timer1_ctrl_reg_o,
   output logic [3:0]       timer2_ctrl_reg_o,
   output logic [3:0]       timer3_ctrl_reg_o,
   output logic [3:0]       timer4_ctrl_reg_o,
   output logic [3:0]       timer6_ctrl_reg_o,
   output logic [1:0]       watchdog_flags_o,
   output logic             watchdog_enable_flag_o,
   // Clock, serial, converter and comparator control
   output logic [3:0]       clock_ctrl_reg_o,
   output logic [3:0]       serial_mode_reg_o,
   output logic             serial_done_flag_o,
   output logic [3:0]       keyon_wake_ctrl_reg_o,
   output logic [3:0]       adc_ctrl_a_reg_o,
   output logic [3:0]       adc_ctrl_b_reg_o,
   output logic             conversion_done_flag_o,
   output logic [3:0]       comparator_ctrl_reg_o
);
   logic                 pin_n_s;
   logic                 drop_s;
   logic                 wake_s;
   logic                 cold_rst;
   logic                 reset_all;
   rsrb_pkg::rsrb_state_e state;
   rsrb_pkg::rsrb_state_e next_state;
   logic                 standby;
   logic                 next_standby;
   logic [2:0]           async_raw;
   logic [2:0]           async_s;

   // Reset-value register group, one field per control output
   typedef struct packed {
      logic [3:0]  port_latch;
      logic [3:0]  pullup_ctrl;
      logic [3:0]  port5_dir;
      logic [12:0] pc_load;
      logic        irq_allow;
      logic [5:0]  irq_req;
      logic [3:0]  irq_ctrl1;
      logic [3:0]  irq_ctrl2;
      logic [3:0]  timer1_ctrl;
      logic [3:0]  timer2_ctrl;
      logic [3:0]  timer3_ctrl;
      logic [3:0]  timer4_ctrl;
      logic [3:0]  timer6_ctrl;
      logic [1:0]  wdog_flags;
      logic        wdog_enable;
      logic [3:0]  clock_ctrl;
      logic [3:0]  serial_mode;
      logic        serial_done;
      logic [3:0]  keyon_wake;
      logic [3:0]  adc_ctrl_a;
      logic [3:0]  adc_ctrl_b;
      logic        conv_done;
      logic [3:0]  comparator;
   } rsrb_init_s;

   rsrb_init_s           init_vals;
   rsrb_init_s           next_init_vals;

   // Synchronise asynchronous sources: bit 0 pin, bit 1 drop, bit 2 wakeup
   assign async_raw = {wakeup_i, supply_drop_i, reset_pin_n_i};
   for (genvar g = 0; g < 3; g++) begin : g_sync
      rsrb_sync u_sync (
         .clk_sys_i (clk_sys_i),
         .nrst_i    (nrst_i),
         .d_i       (async_raw[g]),
         .q_o       (async_s[g])
      );
   end

   // Name the synchronised sources
   assign pin_n_s = async_s[0];
   assign drop_s  = async_s[1];
   assign wake_s  = async_s[2];

   // Cold reset sources; pin sync resets to 0 so reset holds until pin seen high
   // supply drop and watchdog reset
   assign cold_rst  = !pin_n_s || drop_s || watchdog_rst_i;
   // Reset values apply for nrst_i or any cold source
   assign reset_all = !nrst_i || cold_rst;

   // Sequencer and standby flag next values
   always_comb begin
      next_state   = state;
      next_standby = standby;
      unique case (state)
         rsrb_pkg::RSRB_RUN: begin
            if (instr_valid_i && power_off_arm_op_i) begin
               next_state = rsrb_pkg::RSRB_ARMED;
            end
         end
         rsrb_pkg::RSRB_ARMED: begin
            if (instr_valid_i) begin
               if (power_off_op_i) begin
                  next_state = rsrb_pkg::RSRB_BACKUP;
               end else if (!power_off_arm_op_i) begin
                  next_state = rsrb_pkg::RSRB_RUN;
               end
            end
         end
         rsrb_pkg::RSRB_BACKUP: begin
            if (wake_s) begin
               next_state   = rsrb_pkg::RSRB_RUN;
               next_standby = 1'b1;
            end
         end
      endcase
      if (cold_rst) begin
         next_state   = rsrb_pkg::RSRB_RUN;
         next_standby = 1'b0;
      end
   end

   // Sequencer registers
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         state   <= rsrb_pkg::RSRB_RUN;
         standby <= 1'b0;
      end else begin
         state   <= next_state;
         standby <= next_standby;
      end
   end

   assign osc_run_o      = (state != rsrb_pkg::RSRB_BACKUP);
   assign backup_o       = (state == rsrb_pkg::RSRB_BACKUP);
   assign standby_flag_o = standby;
   // Core reset from nrst_i or a cold source; back-up alone does not reset
   assign sys_rst_o      = reset_all;

   assign port_oe_o   = !reset_all;
   assign pullup_en_o = !reset_all && (pullup_ctrl_reg_o != rsrb_pkg::NIB_ZERO_RST);

   // all reset values applied together and held
   always_comb begin
      next_init_vals = init_vals;
      if (reset_all) begin
         next_init_vals.port_latch  = rsrb_pkg::LATCH_ONE_RST;
         next_init_vals.pullup_ctrl = rsrb_pkg::NIB_ZERO_RST;
         next_init_vals.port5_dir   = rsrb_pkg::NIB_ZERO_RST;
         next_init_vals.pc_load     = rsrb_pkg::PC_RST;
         next_init_vals.irq_allow   = 1'b0;
         next_init_vals.irq_req     = 6'h00;
         next_init_vals.irq_ctrl1   = rsrb_pkg::NIB_ZERO_RST;
         next_init_vals.irq_ctrl2   = rsrb_pkg::NIB_ZERO_RST;
         next_init_vals.timer1_ctrl = rsrb_pkg::NIB_ZERO_RST;
         next_init_vals.timer2_ctrl = rsrb_pkg::NIB_ZERO_RST;
         next_init_vals.timer3_ctrl = rsrb_pkg::NIB_ZERO_RST;
         next_init_vals.timer4_ctrl = rsrb_pkg::NIB_ZERO_RST;
         next_init_vals.timer6_ctrl = rsrb_pkg::NIB_ZERO_RST;
         next_init_vals.wdog_flags  = 2'h0;
         next_init_vals.wdog_enable = 1'b0;
         next_init_vals.clock_ctrl  = rsrb_pkg::CLK_CTRL_RST;
         next_init_vals.serial_mode = rsrb_pkg::NIB_ZERO_RST;
         next_init_vals.serial_done = 1'b0;
         next_init_vals.keyon_wake  = rsrb_pkg::NIB_ZERO_RST;
         next_init_vals.adc_ctrl_a  = rsrb_pkg::NIB_ZERO_RST;
         next_init_vals.adc_ctrl_b  = rsrb_pkg::NIB_ZERO_RST;
         next_init_vals.conv_done   = 1'b0;
         next_init_vals.comparator  = rsrb_pkg::NIB_ZERO_RST;
      end
   end

   // Reset-value registers; unknown until the first reset
   always_ff @(posedge clk_sys_i) begin
      init_vals <= next_init_vals;
   end

   // Each control output straight from its register field
   assign port_latch_o           = init_vals.port_latch;
   assign pullup_ctrl_reg_o      = init_vals.pullup_ctrl;
   assign port5_direction_reg_o  = init_vals.port5_dir;
   assign pc_load_o              = init_vals.pc_load;
   assign global_irq_allow_o     = init_vals.irq_allow;
   assign irq_req_flags_o        = init_vals.irq_req;
   assign irq_ctrl1_reg_o        = init_vals.irq_ctrl1;
   assign irq_ctrl2_reg_o        = init_vals.irq_ctrl2;
   assign timer1_ctrl_reg_o      = init_vals.timer1_ctrl;
   assign timer2_ctrl_reg_o      = init_vals.timer2_ctrl;
   assign timer3_ctrl_reg_o      = init_vals.timer3_ctrl;
   assign timer4_ctrl_reg_o      = init_vals.timer4_ctrl;
   assign timer6_ctrl_reg_o      = init_vals.timer6_ctrl;
   assign watchdog_flags_o       = init_vals.wdog_flags;
   assign watchdog_enable_flag_o = init_vals.wdog_enable;
   assign clock_ctrl_reg_o       = init_vals.clock_ctrl;
   assign serial_mode_reg_o      = init_vals.serial_mode;
   assign serial_done_flag_o     = init_vals.serial_done;
   assign keyon_wake_ctrl_reg_o  = init_vals.keyon_wake;
   assign adc_ctrl_a_reg_o       = init_vals.adc_ctrl_a;
   assign adc_ctrl_b_reg_o       = init_vals.adc_ctrl_b;
   assign conversion_done_flag_o = init_vals.conv_done;
   assign comparator_ctrl_reg_o  = init_vals.comparator;
endmodule
`default_nettype wire

// ---- src/rsrb_sync.sv ----
// Two-flop synchroniser for asynchronous single-bit inputs.
// Assumes one clock domain, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module rsrb_sync (
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic nrst_i,
   // Data
   input  wire logic d_i,
   output logic      q_o
);
   logic stage1;
   logic next_stage1;
   logic next_q;

   // Next values of both stages
   always_comb begin
      next_stage1 = d_i;
      next_q      = stage1;
   end

   // Register stages; reset takes constants only
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         stage1 <= 1'b0;
         q_o    <= 1'b0;
      end else begin
         stage1 <= next_stage1;
         q_o    <= next_q;
      end
   end
endmodule
`default_nettype wire

// ---- tb/rsrb_seq_chk.sv ----
// Port checker for the reset and back-up sequencer.
// Assumes one clock; bound onto rsrb_seq below.
`timescale 1ns/1ps
`default_nettype none
module rsrb_seq_chk (
   // Clock, reset and sources
   input wire logic        clk_sys_i,
   input wire logic        nrst_i,
   input wire logic        supply_drop_i,
   input wire logic        wakeup_i,
   input wire logic        watchdog_rst_i,
   input wire logic        instr_valid_i,
   input wire logic        power_off_arm_op_i,
   input wire logic        power_off_op_i,
   // Watched outputs
   input wire logic        sys_rst_o,
   input wire logic        osc_run_o,
   input wire logic        backup_o,
   input wire logic        standby_flag_o,
   input wire logic        port_oe_o,
   input wire logic        pullup_en_o,
   input wire logic [3:0]  port_latch_o,
   input wire logic [3:0]  clock_ctrl_reg_o,
   input wire logic [12:0] pc_load_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   // Arm op then power-off op
   sequence arm_off_s;
      instr_valid_i && power_off_arm_op_i && !sys_rst_o ##1
      instr_valid_i && power_off_op_i && !power_off_arm_op_i && !sys_rst_o;
   endsequence
   // Plain op then power-off op
   sequence plain_off_s;
      instr_valid_i && !power_off_arm_op_i && !power_off_op_i ##1
      instr_valid_i && power_off_op_i && !power_off_arm_op_i;
   endsequence
   port_hiz_a: assert property (sys_rst_o |-> !port_oe_o && !pullup_en_o)
      else $error("ports driven in reset");
   enter_bkp_a: assert property (arm_off_s |=> backup_o)
      else $error("no back-up after arm and power-off");
   nop_off_a: assert property (plain_off_s |=> !backup_o)
      else $error("lone power-off entered back-up");
   osc_stop_a: assert property (osc_run_o != backup_o)
      else $error("oscillator state wrong");
   stay_bkp_a: assert property ((!wakeup_i)[*4] ##0 backup_o && !sys_rst_o |=> backup_o)
      else $error("left back-up without wakeup");
   warm_flag_a: assert property ($fell(backup_o) && !$past(sys_rst_o) |-> standby_flag_o)
      else $error("standby flag not set on wake");
   cold_flag_a: assert property (sys_rst_o |=> !standby_flag_o && !backup_o)
      else $error("cold start left standby or back-up");
   rst_vals_a: assert property (sys_rst_o |=> port_latch_o == rsrb_pkg::LATCH_ONE_RST
      && clock_ctrl_reg_o == rsrb_pkg::CLK_CTRL_RST && pc_load_o == rsrb_pkg::PC_RST)
      else $error("reset values wrong");
   drop_rst_a: assert property (supply_drop_i[*3] |-> sys_rst_o)
      else $error("supply drop gave no reset");
   wdog_rst_a: assert property (watchdog_rst_i |-> sys_rst_o)
      else $error("watchdog gave no reset");
endmodule
bind rsrb_seq rsrb_seq_chk chk (.*);
`default_nettype wire

// ---- tb/rsrb_src.sv ----
// Far-side model: reset pin, supply-drop detector and wakeup source.
// Assumes the bench calls drive() just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module rsrb_src (
   // Clock
   input  wire logic clk_sys_i,
   // Lines into the sequencer
   output var logic  pin_n_o,
   output var logic  drop_o,
   output var logic  wake_o
);
   // Idle: pin pulled up, detector and wakeup quiet
   initial begin
      pin_n_o = 1'b1;
      drop_o = 1'b0;
      wake_o = 1'b0;
   end
   // Assert one source (0 pin, 1 drop, 2 wake) for n cycles
   task automatic drive(input int which, input int n);
      pin_n_o = (which != 0);
      drop_o = (which == 1);
      wake_o = (which == 2);
      repeat (n) @(posedge clk_sys_i);
      #1;
      pin_n_o = 1'b1;
      drop_o = 1'b0;
      wake_o = 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- tb/test_rsrb_seq.sv ----
// Self-checking bench for the reset and back-up sequencer.
// Assumes rsrb_src as far side and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_rsrb_seq;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic watchdog_rst_i = 1'b0;
   logic instr_valid_i = 1'b0;
   logic power_off_arm_op_i = 1'b0;
   logic power_off_op_i = 1'b0;
   logic reset_pin_n_i, supply_drop_i, wakeup_i, sys_rst_o, osc_run_o, backup_o;
   logic standby_flag_o, port_oe_o, pullup_en_o, global_irq_allow_o, serial_done_flag_o;
   logic conversion_done_flag_o, watchdog_enable_flag_o;
   logic [3:0] port_latch_o, pullup_ctrl_reg_o, port5_direction_reg_o, irq_ctrl1_reg_o;
   logic [3:0] irq_ctrl2_reg_o, timer1_ctrl_reg_o, timer2_ctrl_reg_o, timer3_ctrl_reg_o;
   logic [3:0] timer4_ctrl_reg_o, timer6_ctrl_reg_o, clock_ctrl_reg_o, serial_mode_reg_o;
   logic [3:0] keyon_wake_ctrl_reg_o, adc_ctrl_a_reg_o, adc_ctrl_b_reg_o, comparator_ctrl_reg_o;
   logic [12:0] pc_load_o;
   logic [5:0] irq_req_flags_o;
   logic [1:0] watchdog_flags_o;
   int bad_count = 0;
   int checks_done = 0;
   // Row: valid, arm, power-off per slot, and whether back-up follows
   typedef struct packed { logic [2:0] v, a, p; logic bkp; } rsrb_row_s;
   rsrb_row_s rows [6] = '{'{3'h3, 3'h2, 3'h1, 1'b1}, '{3'h7, 3'h6, 3'h1, 1'b1},
      '{3'h5, 3'h4, 3'h1, 1'b1}, '{3'h3, 3'h0, 3'h1, 1'b0}, '{3'h3, 3'h0, 3'h3, 1'b0},
      '{3'h7, 3'h4, 3'h1, 1'b0}};
   rsrb_seq dut (.*);
   rsrb_src src (.clk_sys_i, .pin_n_o(reset_pin_n_i), .drop_o(supply_drop_i), .wake_o(wakeup_i));
   // Machine clock
   always #20 clk_sys_i = ~clk_sys_i;
   // Wait n edges, then step off the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   // Compare and count
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Issue three instruction slots back to back
   task automatic seq(input logic [2:0] v, input logic [2:0] a, input logic [2:0] p);
      for (int i = 2; i >= 0; i--) begin
         instr_valid_i = v[i];
         power_off_arm_op_i = a[i];
         power_off_op_i = p[i];
         cyc(1);
      end
      instr_valid_i = 1'b0;
   endtask
   // Register reset values
   task automatic chk_rst();
      chk({port_latch_o, clock_ctrl_reg_o, pc_load_o}, {4'hF, 4'h8, 13'h0000});
      chk({pullup_ctrl_reg_o, port5_direction_reg_o, global_irq_allow_o, irq_req_flags_o,
         irq_ctrl1_reg_o, irq_ctrl2_reg_o, timer1_ctrl_reg_o, timer2_ctrl_reg_o,
         timer3_ctrl_reg_o, timer4_ctrl_reg_o, timer6_ctrl_reg_o, watchdog_flags_o,
         watchdog_enable_flag_o, serial_mode_reg_o, serial_done_flag_o, keyon_wake_ctrl_reg_o,
         adc_ctrl_a_reg_o, adc_ctrl_b_reg_o, conversion_done_flag_o, comparator_ctrl_reg_o}, '0);
   endtask
   // Counts and verdict
   task automatic stop_test();
      $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      #80000;
      bad_count++;
      stop_test();
   end
   // Main sequence
   initial begin
      cyc(8);
      chk({sys_rst_o, port_oe_o, pullup_en_o}, 3'b100);
      chk_rst();
      nrst_i = 1'b1;
      cyc(4);
      chk({sys_rst_o, osc_run_o, backup_o, standby_flag_o}, 4'b0100);
      $display("reset test done");
      foreach (rows[i]) begin
         seq(rows[i].v, rows[i].a, rows[i].p);
         chk({backup_o, osc_run_o}, {rows[i].bkp, !rows[i].bkp});
         if (rows[i].bkp) begin
            cyc(5);
            chk({backup_o, osc_run_o}, 2'b10);
            src.drive(2, 3);
            cyc(3);
            chk({backup_o, standby_flag_o}, 2'b01);
         end
         $display("row %0d done", i);
      end
      seq(3'h3, 3'h2, 3'h1);
      src.drive(1, 3);
      chk({sys_rst_o, port_oe_o}, 2'b10);
      cyc(3);
      chk({backup_o, standby_flag_o, sys_rst_o}, 3'b000);
      $display("drop test done");
      seq(3'h3, 3'h2, 3'h1);
      src.drive(0, 3);
      chk(sys_rst_o, 1'b1);
      cyc(4);
      chk({backup_o, osc_run_o, sys_rst_o}, 3'b010);
      chk_rst();
      $display("pin test done");
      seq(3'h3, 3'h2, 3'h1);
      src.drive(2, 3);
      cyc(3);
      watchdog_rst_i = 1'b1;
      cyc(1);
      watchdog_rst_i = 1'b0;
      chk({standby_flag_o, backup_o}, 2'b00);
      $display("watchdog test done");
      stop_test();
   end
endmodule
`default_nettype wire
